// *** adc_ovr_pkg.sv ***
// Purpose: shared constants and carriers for the overrange/timestamp output block
// Assumes: 32-bit classic Wishbone, byte addresses, one clock
// Notes:   offsets are byte addresses of aligned words
package adc_ovr_pkg;
  // Sample and magnitude geometry
  localparam int          DATA_W         = 12;
  localparam int          MAG_W          = 11;
  localparam int          THR_W          = 8;
  localparam int          MAG_CMP_LSB    = 3;
  localparam logic [11:0] CODE_MOST_NEG  = 12'h800;
  localparam logic [10:0] MAG_SAT        = 11'h7FF;
  // Flag hold
  localparam int          HOLD_SEL_W     = 3;
  localparam int          HOLD_BASE_LOG2 = 3;
  localparam int          HOLD_CNT_W     = 11;
  localparam logic [10:0] HOLD_ONE       = 11'h001;
  // Pipeline
  localparam int          DATA_LAT       = 4;
  localparam int          SYNC_STAGES    = 2;
  // Calibration
  localparam int          FG_CAL_CYCLES  = 1024;
  localparam int          CAL_CNT_W      = 11;
  localparam int          SWAP_CYCLES    = 256;
  localparam int          SWAP_CNT_W     = 9;
  localparam logic [2:0]  SPARE_CORE_A   = 3'h4;
  localparam logic [2:0]  SPARE_CORE_B   = 3'h5;
  // Register map
  localparam int          WB_AW          = 8;
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_THRESH     = 8'h04;
  localparam logic [7:0]  REG_HOLD       = 8'h08;
  localparam logic [7:0]  REG_STATUS     = 8'h0C;
  localparam int          CTRL_SINGLE    = 0;
  localparam int          CTRL_MARK_EN   = 1;
  localparam int          CTRL_SYSREF    = 2;
  localparam int          CTRL_BG_CAL    = 3;
  localparam int          CTRL_FG_START  = 4;
  localparam int          THR_HIGH_LSB   = 0;
  localparam int          THR_LOW_LSB    = 8;
  localparam int          STAT_FG_BUSY   = 4;
  localparam int          STAT_CORE_LSB  = 5;
  localparam logic [7:0]  THR_HIGH_RST   = 8'hFF;
  localparam logic [7:0]  THR_LOW_RST    = 8'hFF;
  localparam logic [2:0]  HOLD_SEL_RST   = 3'h0;

  typedef struct packed {
    logic [11:0] code;
    logic [11:0] dither;
  } core_word_s;

  typedef struct packed {
    logic [11:0] a;
    logic [11:0] b;
    logic        valid;
  } lanes_s;
endpackage

// *** delay_line.sv ***
// Purpose: fixed-latency register pipeline
// Assumes: DEPTH of at least one
// Notes:   output comes straight from the last stage
`timescale 1ns/10ps
module delay_line #(
  parameter int W     = 1,
  parameter int DEPTH = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] stage_q [DEPTH];
  logic [W-1:0] stage_d [DEPTH];

  always_comb
  begin
    stage_d[0] = d_i;
    for (int i = 1; i < DEPTH; i++)
    begin
      stage_d[i] = stage_q[i-1];
    end
  end

  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      if (rst_i)
        stage_q[i] <= '0;
      else
        stage_q[i] <= stage_d[i];
    end
  end

  assign q_o = stage_q[DEPTH-1];
endmodule // delay_line

// *** ovr_flag_hold.sv ***
// Purpose: one overrange flag with a retriggerable hold time
// Assumes: len_i is at least one cycle
// Notes:   flag rises the cycle after the event, stays len_i cycles
`timescale 1ns/10ps
module ovr_flag_hold #(
  parameter int CNT_W = adc_ovr_pkg::HOLD_CNT_W
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Event and hold length
  input  wire logic             event_i,
  input  wire logic [CNT_W-1:0] len_i,
  output logic                  flag_o
);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             flag_q, flag_d;
  logic [CNT_W-1:0] run_q, lenl_q;

  always_comb
  begin
    cnt_d = cnt_q;
    if (event_i)
      cnt_d = len_i;
    else if (cnt_q != '0)
      cnt_d = cnt_q - 1'b1;
    flag_d = (cnt_d != '0);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q  <= '0;
      flag_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

  // Helper: flag-high cycles since the last event
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_q  <= '0;
      lenl_q <= '0;
    end
    else if (event_i)
    begin
      run_q  <= '0;
      lenl_q <= len_i;
    end
    else if (flag_q)
      run_q <= run_q + 1'b1;
  end

  chk_event_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    event_i |=> flag_o) else $error("flag not set after overrange event");
  chk_hold_length: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(flag_o) |-> run_q == lenl_q) else $error("flag hold length wrong");
  chk_reset_clear: assert property (@(posedge clk_i)
    rst_i |=> !flag_o) else $error("flag not clear after reset");
endmodule // ovr_flag_hold

// *** adc_overrange_timestamp_output.sv ***
// Purpose: sample output, overrange flags, timestamp marking, core steering
// Assumes: converted codes and dither arrive on clk_i; trigger and sysref are async
// Notes:   lane b carries the falling-edge sample in single-channel mode
//
// Overview of operation
// - Samples are signed two's complement; negative when minus input is higher.
// - Dual mode samples on rising edge; single mode on both edges.
// - Magnitude of sample is 11 bits; most negative code saturates to 2047.
// - Upper eight magnitude bits compare against two programmable thresholds.
// - Both channels share the same pair of thresholds in dual mode.
// - Flag is 1 when compared bits reach the threshold, else 0.
// - Dual mode: channel A flags on one pin pair, B on another.
// - Single mode: each threshold status spread over both matching flag pins.
// - Hold select 0..7 keeps flag 8 to 1024 cycles after last event.
// - Calibration runs foreground, stopping samples, or background, continuing.
// - With marking on, sample keeps upper 11 bits; LSB holds the mark.
// - Mark path latency equals the data path latency.
// - Trigger input may be asynchronous; sampled alongside the analog input.
// - With sysref select set, system reference replaces the trigger as mark.
// - Injected dither is subtracted from converted data.
// - Cores interleave two-way per channel dual, four-way single; swap for calibration.
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/10ps
module adc_overrange_timestamp_output #(
  parameter int FG_CAL_CYCLES = adc_ovr_pkg::FG_CAL_CYCLES
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  // Converter cores
  input  wire adc_ovr_pkg::core_word_s core_a_i,
  input  wire adc_ovr_pkg::core_word_s core_b_i,
  // Asynchronous mark sources
  input  wire logic                   trigger_mark_input_i,
  input  wire logic                   sysref_i,
  // Sample output
  output logic      [11:0]            sample_a_o,
  output logic      [11:0]            sample_b_o,
  output logic                        sample_valid_o,
  output logic      [2:0]             core_a_o,
  output logic      [2:0]             core_b_o,
  output logic                        fg_cal_busy_o,
  // Overrange flag pins
  output logic                        chan_a_flag_high_o,
  output logic                        chan_a_flag_low_o,
  output logic                        chan_b_flag_high_o,
  output logic                        chan_b_flag_low_o
);
  localparam int DW      = adc_ovr_pkg::DATA_W;
  localparam int MW      = adc_ovr_pkg::MAG_W;
  localparam int TW      = adc_ovr_pkg::THR_W;
  localparam int LAT     = adc_ovr_pkg::DATA_LAT;
  localparam int OUT_LAT = LAT + 1;
  localparam int MRK_LAT = LAT - adc_ovr_pkg::SYNC_STAGES + 1;
  localparam logic [10:0] FG_LOAD = 11'(FG_CAL_CYCLES);

  function automatic logic [10:0] mag_of(input logic [11:0] c);
    logic [11:0] neg;
    neg = -c;
    if (c == adc_ovr_pkg::CODE_MOST_NEG)
      mag_of = adc_ovr_pkg::MAG_SAT;
    else if (c[DW-1])
      mag_of = neg[MW-1:0];
    else
      mag_of = c[MW-1:0];
  endfunction

  // Register state
  logic       single_q, single_d, mark_en_q, mark_en_d, sysref_sel_q, sysref_sel_d;
  logic       bg_cal_q, bg_cal_d, ack_q, ack_d;
  logic [7:0] thr_high_q, thr_high_d, thr_low_q, thr_low_d;
  logic [2:0] hold_sel_q, hold_sel_d;
  logic [31:0] rdat_q, rdat_d, rd_mux;
  logic       wr_en;
  logic [1:0] cal_core_q, cal_core_d;

  always_comb
  begin
    rd_mux = '0;
    case (wb_adr_i)
      adc_ovr_pkg::REG_CTRL:
      begin
        rd_mux[adc_ovr_pkg::CTRL_SINGLE]  = single_q;
        rd_mux[adc_ovr_pkg::CTRL_MARK_EN] = mark_en_q;
        rd_mux[adc_ovr_pkg::CTRL_SYSREF]  = sysref_sel_q;
        rd_mux[adc_ovr_pkg::CTRL_BG_CAL]  = bg_cal_q;
      end
      adc_ovr_pkg::REG_THRESH:
      begin
        rd_mux[adc_ovr_pkg::THR_HIGH_LSB +: TW] = thr_high_q;
        rd_mux[adc_ovr_pkg::THR_LOW_LSB +: TW]  = thr_low_q;
      end
      adc_ovr_pkg::REG_HOLD:
        rd_mux[adc_ovr_pkg::HOLD_SEL_W-1:0] = hold_sel_q;
      adc_ovr_pkg::REG_STATUS:
      begin
        rd_mux[3:0] = {chan_a_flag_high_o, chan_a_flag_low_o,
                       chan_b_flag_high_o, chan_b_flag_low_o};
        rd_mux[adc_ovr_pkg::STAT_FG_BUSY] = fg_cal_busy_o;
        rd_mux[adc_ovr_pkg::STAT_CORE_LSB +: 3] = {1'b0, cal_core_q};
      end
      default:
        rd_mux = '0;
    endcase
  end

  // Write lands on the edge that samples ack
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

  always_comb
  begin
    ack_d        = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d       = ack_d ? rd_mux : rdat_q;
    single_d     = single_q;
    mark_en_d    = mark_en_q;
    sysref_sel_d = sysref_sel_q;
    bg_cal_d     = bg_cal_q;
    thr_high_d   = thr_high_q;
    thr_low_d    = thr_low_q;
    hold_sel_d   = hold_sel_q;
    if (wr_en && wb_adr_i == adc_ovr_pkg::REG_CTRL && wb_sel_i[0])
    begin
      single_d     = wb_dat_i[adc_ovr_pkg::CTRL_SINGLE];
      mark_en_d    = wb_dat_i[adc_ovr_pkg::CTRL_MARK_EN];
      sysref_sel_d = wb_dat_i[adc_ovr_pkg::CTRL_SYSREF];
      bg_cal_d     = wb_dat_i[adc_ovr_pkg::CTRL_BG_CAL];
    end
    if (wr_en && wb_adr_i == adc_ovr_pkg::REG_THRESH)
    begin
      if (wb_sel_i[0])
        thr_high_d = wb_dat_i[adc_ovr_pkg::THR_HIGH_LSB +: TW];
      if (wb_sel_i[1])
        thr_low_d = wb_dat_i[adc_ovr_pkg::THR_LOW_LSB +: TW];
    end
    if (wr_en && wb_adr_i == adc_ovr_pkg::REG_HOLD && wb_sel_i[0])
      hold_sel_d = wb_dat_i[adc_ovr_pkg::HOLD_SEL_W-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q        <= 1'b0;
      rdat_q       <= '0;
      single_q     <= 1'b0;
      mark_en_q    <= 1'b0;
      sysref_sel_q <= 1'b0;
      bg_cal_q     <= 1'b0;
      thr_high_q   <= adc_ovr_pkg::THR_HIGH_RST;
      thr_low_q    <= adc_ovr_pkg::THR_LOW_RST;
      hold_sel_q   <= adc_ovr_pkg::HOLD_SEL_RST;
    end
    else
    begin
      ack_q        <= ack_d;
      rdat_q       <= rdat_d;
      single_q     <= single_d;
      mark_en_q    <= mark_en_d;
      sysref_sel_q <= sysref_sel_d;
      bg_cal_q     <= bg_cal_d;
      thr_high_q   <= thr_high_d;
      thr_low_q    <= thr_low_d;
      hold_sel_q   <= hold_sel_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Calibration and core steering
  logic [10:0] fg_cnt_q, fg_cnt_d;
  logic [8:0]  swap_cnt_q, swap_cnt_d;
  logic        rot_q, rot_d;
  logic [2:0]  core_a_q, core_a_d, core_b_q, core_b_d;
  logic        fg_start;

  assign fg_start = wr_en && wb_adr_i == adc_ovr_pkg::REG_CTRL && wb_sel_i[0]
                    && wb_dat_i[adc_ovr_pkg::CTRL_FG_START];

  // foreground stops sampling, background keeps it
  // two-way or four-way interleave with spare swap
  always_comb
  begin
    fg_cnt_d   = fg_start ? FG_LOAD : (fg_cnt_q != '0) ? fg_cnt_q - 1'b1 : fg_cnt_q;
    rot_d      = !rot_q;
    swap_cnt_d = swap_cnt_q;
    cal_core_d = cal_core_q;
    if (bg_cal_q)
    begin
      swap_cnt_d = (swap_cnt_q == 9'(adc_ovr_pkg::SWAP_CYCLES - 1)) ? '0 : swap_cnt_q + 1'b1;
      if (swap_cnt_d == '0)
        cal_core_d = cal_core_q + 1'b1;
    end
    // lane b holds the falling-edge sample
    if (single_q)
    begin
      core_a_d = {1'b0, rot_q, 1'b0};
      core_b_d = {1'b0, rot_q, 1'b1};
    end
    else
    begin
      core_a_d = {2'b00, rot_q};
      core_b_d = {2'b01, rot_q};
    end
    if (bg_cal_q && core_a_d[1:0] == cal_core_q)
      core_a_d = adc_ovr_pkg::SPARE_CORE_A;
    if (bg_cal_q && core_b_d[1:0] == cal_core_q)
      core_b_d = adc_ovr_pkg::SPARE_CORE_B;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fg_cnt_q   <= '0;
      swap_cnt_q <= '0;
      cal_core_q <= '0;
      rot_q      <= 1'b0;
      core_a_q   <= '0;
      core_b_q   <= '0;
    end
    else
    begin
      fg_cnt_q   <= fg_cnt_d;
      swap_cnt_q <= swap_cnt_d;
      cal_core_q <= cal_core_d;
      rot_q      <= rot_d;
      core_a_q   <= core_a_d;
      core_b_q   <= core_b_d;
    end
  end

  assign fg_cal_busy_o = (fg_cnt_q != '0);
  assign core_a_o      = core_a_q;
  assign core_b_o      = core_b_q;

  // dither removal; result stays two's complement
  logic [11:0] corr_a, corr_b;
  logic [7:0]  cmp_a, cmp_b;
  logic [10:0] mag_a, mag_b, hold_len;
  logic        ev_ah, ev_al, ev_bh, ev_bl;

  assign corr_a = core_a_i.code - core_a_i.dither;
  assign corr_b = core_b_i.code - core_b_i.dither;
  assign mag_a  = mag_of(corr_a);
  assign mag_b  = mag_of(corr_b);

  // upper eight bits; one threshold pair for both lanes
  assign cmp_a  = mag_a[adc_ovr_pkg::MAG_CMP_LSB +: TW];
  assign cmp_b  = mag_b[adc_ovr_pkg::MAG_CMP_LSB +: TW];
  // at-or-above test, no events while sampling is stopped
  assign ev_ah  = !fg_cal_busy_o && (cmp_a >= thr_high_q);
  assign ev_al  = !fg_cal_busy_o && (cmp_a >= thr_low_q);
  assign ev_bh  = !fg_cal_busy_o && (cmp_b >= thr_high_q);
  assign ev_bl  = !fg_cal_busy_o && (cmp_b >= thr_low_q);
  assign hold_len = adc_ovr_pkg::HOLD_ONE << (adc_ovr_pkg::HOLD_BASE_LOG2 + hold_sel_q);

  // lane a drives A pins, lane b drives B pins in either mode
  ovr_flag_hold u_hold_ah (.clk_i(clk_i), .rst_i(rst_i), .event_i(ev_ah),
                           .len_i(hold_len), .flag_o(chan_a_flag_high_o));
  ovr_flag_hold u_hold_al (.clk_i(clk_i), .rst_i(rst_i), .event_i(ev_al),
                           .len_i(hold_len), .flag_o(chan_a_flag_low_o));
  ovr_flag_hold u_hold_bh (.clk_i(clk_i), .rst_i(rst_i), .event_i(ev_bh),
                           .len_i(hold_len), .flag_o(chan_b_flag_high_o));
  ovr_flag_hold u_hold_bl (.clk_i(clk_i), .rst_i(rst_i), .event_i(ev_bl),
                           .len_i(hold_len), .flag_o(chan_b_flag_low_o));

  // two-flop synchronisers; first stage read by second only
  logic [1:0] trig_sync_q, sref_sync_q;
  logic       mark_src, mark_dly;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trig_sync_q <= '0;
      sref_sync_q <= '0;
    end
    else
    begin
      trig_sync_q <= {trig_sync_q[0], trigger_mark_input_i};
      sref_sync_q <= {sref_sync_q[0], sysref_i};
    end
  end

  assign mark_src = sysref_sel_q ? sref_sync_q[1] : trig_sync_q[1];

  // mark delay trimmed by the synchroniser depth
  adc_ovr_pkg::lanes_s lanes_in, lanes_dly;
  assign lanes_in = '{a: corr_a, b: corr_b, valid: !fg_cal_busy_o};

  delay_line #(.W($bits(adc_ovr_pkg::lanes_s)), .DEPTH(LAT)) u_data_dly (
    .clk_i(clk_i), .rst_i(rst_i), .d_i(lanes_in), .q_o(lanes_dly));
  delay_line #(.W(1), .DEPTH(LAT - adc_ovr_pkg::SYNC_STAGES)) u_mark_dly (
    .clk_i(clk_i), .rst_i(rst_i), .d_i(mark_src), .q_o(mark_dly));

  logic [11:0] out_a_q, out_a_d, out_b_q, out_b_d;
  logic        out_v_q, out_v_d;
  always_comb
  begin
    out_a_d = mark_en_q ? {lanes_dly.a[DW-1:1], mark_dly} : lanes_dly.a;
    out_b_d = mark_en_q ? {lanes_dly.b[DW-1:1], mark_dly} : lanes_dly.b;
    out_v_d = lanes_dly.valid;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_a_q <= '0;
      out_b_q <= '0;
      out_v_q <= 1'b0;
    end
    else
    begin
      out_a_q <= out_a_d;
      out_b_q <= out_b_d;
      out_v_q <= out_v_d;
    end
  end

  assign sample_a_o     = out_a_q;
  assign sample_b_o     = out_b_q;
  assign sample_valid_o = out_v_q;

  chk_mag_saturate: assert property (@(posedge clk_i) disable iff (rst_i)
    corr_a == adc_ovr_pkg::CODE_MOST_NEG |-> cmp_a == 8'hFF)
    else $error("most negative code did not saturate");
  chk_high_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !fg_cal_busy_o && mag_a[10:3] >= thr_high_q |=> chan_a_flag_high_o)
    else $error("channel A high flag missed");
  chk_shared_thresh: assert property (@(posedge clk_i) disable iff (rst_i)
    !fg_cal_busy_o && mag_b[10:3] >= thr_low_q |=> chan_b_flag_low_o)
    else $error("channel B low flag missed");
  chk_mark_lsb: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(mark_en_q) |-> sample_b_o[0] == $past(mark_src, MRK_LAT))
    else $error("timestamp bit misaligned");
  chk_dither_out: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i, OUT_LAT) == 1'b0 && !$past(mark_en_q) |-> sample_a_o == $past(corr_a, OUT_LAT))
    else $error("output sample is not dither-corrected input");
  chk_fg_stops: assert property (@(posedge clk_i) disable iff (rst_i)
    fg_cal_busy_o |-> ##OUT_LAT !sample_valid_o)
    else $error("samples flowed during foreground calibration");
  chk_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
  chk_core_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && !$past(single_q) && !$past(bg_cal_q)
    |-> core_a_o[2:1] == 2'b00 && core_b_o[2:1] == 2'b01)
    else $error("dual mode core pairing wrong");
endmodule // adc_overrange_timestamp_output

// *** ovr_receiver.sv ***
// Purpose: downstream logic model reading the overrange flag pins
// Assumes: flags are registered levels on clk_i
// Notes:   gain hints only; no real gain loop behind them
`timescale 1ns/10ps
module ovr_receiver (
  // Clock and mode
  input  wire logic clk_i,
  input  wire logic single_i,
  // Flag pins
  input  wire logic a_high_i,
  input  wire logic a_low_i,
  input  wire logic b_high_i,
  input  wire logic b_low_i,
  // Decisions
  output logic      over_high_o,
  output logic      gain_up_o
);
  logic [7:0] quiet_q = 8'h00;
  assign over_high_o = single_i ? (a_high_i | b_high_i) : a_high_i;
  always_ff @(posedge clk_i)
  begin
    quiet_q <= (a_low_i | (single_i & b_low_i)) ? 8'h00 : quiet_q + 8'h01;
  end
  assign gain_up_o = (quiet_q == 8'hFF);
endmodule // ovr_receiver

// *** adc_overrange_timestamp_output_test.sv ***
// Purpose: self-checking bench for the overrange/timestamp output block
// Assumes: register answers arrive whenever the slave acks
// Notes:   foreground calibration shortened to 8 cycles
`timescale 1ns/10ps
module adc_overrange_timestamp_output_test;
  logic        clk_i = 1'h0, rst_i = 1'h1, run = 1'h0, chk = 1'h0;
  logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'h3C78524D;
  logic        trig = 1'h0, sysref = 1'h0, valid, busy, over_high;
  wire  [3:0]  fl;
  logic [2:0]  coa, cob;
  logic [11:0] sa, sb, hist_a[$], hist_b[$];
  logic [7:0]  thr_h = 8'hFF, thr_l = 8'hFF;
  logic [2:0]  hold = 3'h0;
  logic [4:0]  ctrl = 5'h00;
  logic [4:0]  ctrl_q = 5'h00;
  int          cnt[4], miscompares = 0, check_count = 0;
  adc_ovr_pkg::core_word_s ca = '0, cb = '0;
  logic [7:0]  th[4] = '{8'hE4, 8'hFF, 8'hE4, 8'h80};
  logic [7:0]  tl[4] = '{8'h40, 8'h01, 8'h40, 8'h10};
  logic [2:0]  hd[4] = '{3'h0, 3'h1, 3'h7, 3'h0};
  logic [4:0]  ct[4] = '{5'h00, 5'h02, 5'h06, 5'h0B};

  adc_overrange_timestamp_output #(.FG_CAL_CYCLES(8)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_a_i(ca), .core_b_i(cb),
    .trigger_mark_input_i(trig), .sysref_i(sysref), .sample_a_o(sa), .sample_b_o(sb),
    .sample_valid_o(valid), .core_a_o(coa), .core_b_o(cob), .fg_cal_busy_o(busy),
    .chan_a_flag_high_o(fl[3]), .chan_a_flag_low_o(fl[2]),
    .chan_b_flag_high_o(fl[1]), .chan_b_flag_low_o(fl[0]));
  ovr_receiver rx (.clk_i(clk_i), .single_i(ctrl[0]), .a_high_i(fl[3]), .a_low_i(fl[2]),
    .b_high_i(fl[1]), .b_low_i(fl[0]), .over_high_o(over_high), .gain_up_o());

  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Mostly small codes so that flags can fall between events
  function automatic adc_ovr_pkg::core_word_s pick(input logic [31:0] r);
    pick.code = (r[3:0] == 4'h0) ? r[27:16] : {{4{r[15]}}, r[15:8]};
    pick.dither = {{9{r[6]}}, r[6:4]};
    if (r[31:28] == 4'h0)
    begin
      pick.code = 12'h800;
      pick.dither = 12'h000;
    end
  endfunction

  function automatic logic [7:0] mag8(input logic [11:0] d);
    logic [10:0] m;
    m = (d == 12'h800) ? 11'h7FF : (d[11] ? 11'(-d) : d[10:0]);
    return m[10:3];
  endfunction

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    // Only the watchdog ends a wait for ack
    do
    begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] q;
    wb(1'h0, adr, 32'h0, q);
    cmp(what, exp, q);
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    seed = xs(seed);
    ca <= run ? pick(seed) : '0;
    trig <= run & seed[9];
    seed = xs(seed);
    cb <= run ? pick(seed) : '0;
    sysref <= run & seed[9];
  end

  // Reference model: outputs after the previous edge, then this edge's inputs
  always @(posedge clk_i)
  begin
    logic [11:0] da, db, mk;
    logic [1:0]  ok;
    if (chk && hist_a.size() == 5)
    begin
      cmp("sample_a", hist_a[0], sa);
      cmp("sample_b", hist_b[0], sb);
      cmp("valid", 32'h1, valid);
      cmp("flags", {cnt[0] > 0, cnt[1] > 0, cnt[2] > 0, cnt[3] > 0}, fl);
      cmp("or_high", ctrl[0] ? (cnt[0] > 0) | (cnt[2] > 0) : cnt[0] > 0, over_high);
      // Core choice trails the mode by one edge; spare only under background cal
      ok[1] = (ctrl_q[3] && coa == 3'h4)
              || (ctrl_q[0] ? {coa[2], coa[0]} == 2'h0 : coa[2:1] == 2'h0);
      ok[0] = (ctrl_q[3] && cob == 3'h5)
              || (ctrl_q[0] ? {cob[2], cob[0]} == 2'h1 : cob[2:1] == 2'h1);
      cmp("cores", 32'h3, ok);
    end
    da = ca.code - ca.dither;
    db = cb.code - cb.dither;
    mk = ctrl[2] ? sysref : trig;
    for (int i = 0; i < 4; i++)
    begin
      if (rst_i)
        cnt[i] = 0;
      else if (mag8(i < 2 ? da : db) >= (i % 2 ? thr_l : thr_h))
        cnt[i] = 8 << hold;
      else if (cnt[i] > 0)
        cnt[i]--;
    end
    if (!rst_i)
    begin
      hist_a.push_back(ctrl[1] ? {da[11:1], mk[0]} : da);
      hist_b.push_back(ctrl[1] ? {db[11:1], mk[0]} : db);
    end
    if (hist_a.size() > 5)
    begin
      hist_a.pop_front();
      hist_b.pop_front();
    end
    ctrl_q = ctrl;
  end

  initial
  begin
    logic [31:0] q;
    int gap;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    rdc(8'h04, 32'h0000FFFF, "thresh_rst");
    rdc(8'h08, 32'h0, "hold_rst");
    rdc(8'h10, 32'h0, "unmapped");
    chk <= 1'h1;
    for (int p = 0; p < 4; p++)
    begin
      // thresholds, hold, mark enable before use
      wb(1'h1, 8'h04, {16'h0, tl[p], th[p]}, q);
      thr_h <= th[p];
      thr_l <= tl[p];
      wb(1'h1, 8'h08, {29'h0, hd[p]}, q);
      hold <= hd[p];
      wb(1'h1, 8'h00, {27'h0, ct[p]}, q);
      ctrl <= ct[p];
      wb(1'h1, 8'h24, 32'hFFFFFFFF, q);
      rdc(8'h04, {16'h0, tl[p], th[p]}, "thresh");
      rdc(8'h08, {29'h0, hd[p]}, "hold");
      run <= 1'h1;
      repeat (600) @(posedge clk_i);
      run <= 1'h0;
      repeat ((8 << hd[p]) + 12) @(posedge clk_i);
    end
    chk <= 1'h0;
    wb(1'h1, 8'h00, 32'h10, q);
    ctrl <= 5'h00;
    wb(1'h0, 8'h0C, 32'h0, q);
    cmp("status", 32'h10, q & 32'h1F);
    repeat (2) @(posedge clk_i);
    cmp("fg_busy", 32'h1, busy);
    gap = 0;
    repeat (48)
    begin
      @(posedge clk_i);
      if (valid === 1'h0)
        gap = 1;
    end
    cmp("fg_gap", 32'h1, gap);
    cmp("fg_done", 32'h0, busy);
    wrap_up();
  end

  // Runs take about 3650 cycles; the 16000-cycle limit is over four times that
  initial
  begin
    #400000;
    miscompares++;
    wrap_up();
  end
endmodule // adc_overrange_timestamp_output_test
